// >>> hw/bcd_calendar_rtc.sv
// BCD calendar real-time clock with periodic interrupt and byte register port.
//
// Function
// - Counting clock flows only while the clock-gate bit is 1; resets to 0.
// - Periodic event sets the status bit; writing 1 clears it; reserved bits read 0.
// - A 3-bit field picks the interrupt cycle; 6,5,4 give 1/128,1/256,1/512 s.
// - Mode bit 1 gives a level request, 0 gives an edge request.
// - The request reaches the processor only while the enable bit is 1.
// - Hour-format bit 1 counts 24 hours, 0 counts 12 hours with AM/PM.
// - Writing 1 to the adjust bit performs a 30-second adjustment.
// - Divider-stop bit 1 halts the time-base divider.
// - Writing reset 1 then 0 restores cycle 1, level mode, other bits 0.
// - Time and calendar counters keep their values across a software reset.
// - Read-buffer bit 1 serves minute-and-above counter reads from a latched copy; seconds read live.
// - Busy flag reads 1 while the counters are updating.
// - Hold bit 1 stops the counters; 0 lets them run.
// - Seconds and minutes are two BCD digits, tens 0-5, units 0-9.
// - Hours are BCD with two tens bits and a PM flag in bit 6.
// - Day, month and year are BCD with tens ranges 0-3, 0-1, 0-9.
// - Weekday is 0 for Sunday through 6 for Saturday; 7 is invalid.
`timescale 1ns/1ns
`include "rtc_defines.svh"

module bcd_calendar_rtc
    import rtc_pkg::*;
#(
    parameter int OSC_DIV = `RTC_MCLK_HZ / `RTC_OSC_HZ
)
(
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic reset_n_in,
    // Register port.
    input wire logic [15:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    output logic [7:0] rd_data_out,
    // Interrupt and status.
    output logic irq_out,
    output logic counter_busy_out
);

    logic clock_gate_on_q;
    logic periodic_irq_pending_q;
    logic [2:0] irq_period_select_q;
    logic irq_level_mode_q;
    logic periodic_irq_enable_q;
    ctrl_s ctrl_q;
    logic read_buffer_enable_q;
    logic counter_hold_q;
    time_s time_q;
    time_s rdbuf_q;
    time_s rd_view;
    logic [11:0] pre_q;
    logic osc_tick_q;
    logic [14:0] div_q;
    logic sec_pend_q;
    logic edge_q;
    logic one_hz;
    logic per_evt;
    logic soft_apply;
    logic step;
    logic div_run;

    // Write decode shared by the gate, control and status register processes; the counters decode a range.
    function automatic logic wr_hit(input logic [15:0] a, input logic [15:0] ofs);
        return a == ofs;
    endfunction

    // Two-digit BCD increment.
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9)
        begin
            return {v[7:4] + 4'h1, 4'h0};
        end
        return {v[7:4], v[3:0] + 4'h1};
    endfunction

    // Last day of a month, BCD, with leap years every fourth year.
    function automatic logic [5:0] last_day(input logic [4:0] m, input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        if (m == 5'h02)
        begin
            return leap ? 6'h29 : 6'h28;
        end
        if (m == 5'h04 || m == 5'h06 || m == 5'h09 || m == 5'h11)
        begin
            return 6'h30;
        end
        return 6'h31;
    endfunction

    // Mask of divider bits that must all be ones for a periodic event.
    // Code n spans 2^(n+2) ticks, so a larger code gives a longer cycle.
    function automatic logic [14:0] period_mask(input logic [2:0] code);
        return 15'h7fff >> (4'hd - {1'b0, code});
    endfunction

    // Carry from minutes upward, used by the one-second step and the adjustment.
    function automatic time_s carry_min(input time_s t, input logic h24);
        time_s n;
        logic day_c;
        n = t;
        n.sec = 7'h00;
        day_c = 1'b0;
        if (t.min == 7'h59)
        begin
            n.min = 7'h00;
            if (h24)
            begin
                n.hour = (t.hour[5:0] == 6'h23) ? 7'h00
                         : {1'b0, 6'(bcd_inc({2'h0, t.hour[5:0]}))};
                day_c = t.hour[5:0] == 6'h23;
            end
            else if (t.hour[5:0] == 6'h11)
            begin
                n.hour = {~t.hour[6], 6'h12};
                day_c = t.hour[6];
            end
            else
            begin
                n.hour = {t.hour[6], (t.hour[5:0] == 6'h12) ? 6'h01
                                     : 6'(bcd_inc({2'h0, t.hour[5:0]}))};
            end
        end
        else
        begin
            n.min = 7'(bcd_inc({1'b0, t.min}));
        end
        if (day_c)
        begin
            n.wk = (t.wk >= 3'h6) ? 3'h0 : t.wk + 3'h1;
            if (t.day == last_day(t.mon, t.year))
            begin
                n.day = 6'h01;
                if (t.mon == 5'h12)
                begin
                    n.mon = 5'h01;
                    n.year = (t.year == 8'h99) ? 8'h00 : bcd_inc(t.year);
                end
                else
                begin
                    n.mon = 5'(bcd_inc({3'h0, t.mon}));
                end
            end
            else
            begin
                n.day = 6'(bcd_inc({2'h0, t.day}));
            end
        end
        return n;
    endfunction

    assign div_run = osc_tick_q && !ctrl_q.stp && !ctrl_q.rst;
    assign one_hz = div_run && div_q == 15'h7fff;
    assign per_evt = div_run && irq_period_select_q != `RTC_PER_RSVD
                     && (div_q & period_mask(irq_period_select_q))
                        == period_mask(irq_period_select_q);
    assign soft_apply = wr_en_in && wr_hit(addr_in, `RTC_OFS_MAIN) && ctrl_q.rst
                        && !wr_data_in[`RTC_BIT_RST];
    assign step = sec_pend_q && !counter_hold_q;

    // Counter values that reads of minutes and above return.
    assign rd_view = read_buffer_enable_q ? rdbuf_q : time_q;

    // Clock gate register.
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            clock_gate_on_q <= 1'b0;
        end
        else if (wr_en_in && wr_hit(addr_in, `RTC_OFS_GATE))
        begin
            clock_gate_on_q <= wr_data_in[`RTC_BIT_GATE];
        end
    end

    // Low-speed oscillator tick, derived from the bus clock and gated.
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            pre_q <= 12'h000;
            osc_tick_q <= 1'b0;
        end
        else if (!clock_gate_on_q)
        begin
            pre_q <= 12'h000;
            osc_tick_q <= 1'b0;
        end
        else
        begin
            osc_tick_q <= pre_q == 12'(OSC_DIV - 1);
            pre_q <= (pre_q == 12'(OSC_DIV - 1)) ? 12'h000 : pre_q + 12'h001;
        end
    end

    // Time-base divider; frozen while stopped or in software reset.
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            div_q <= 15'h0000;
        end
        else if (div_run)
        begin
            div_q <= div_q + 15'h0001;
        end
    end

    // Interrupt setup and control registers, with the software reset defaults.
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            irq_period_select_q <= `RTC_PER_RST;
            irq_level_mode_q <= `RTC_LEVEL_RST;
            periodic_irq_enable_q <= 1'b0;
            ctrl_q <= '0;
            read_buffer_enable_q <= 1'b0;
            counter_hold_q <= 1'b0;
        end
        else if (soft_apply)
        begin
            irq_period_select_q <= `RTC_PER_RST;
            irq_level_mode_q <= `RTC_LEVEL_RST;
            periodic_irq_enable_q <= 1'b0;
            ctrl_q <= '0;
            read_buffer_enable_q <= 1'b0;
            counter_hold_q <= 1'b0;
        end
        else
        begin
            ctrl_q.adj <= 1'b0;
            if (wr_en_in && wr_hit(addr_in, `RTC_OFS_SETUP))
            begin
                irq_period_select_q <= wr_data_in[`RTC_PER_MSB:`RTC_PER_LSB];
                irq_level_mode_q <= wr_data_in[`RTC_BIT_LEVEL];
                periodic_irq_enable_q <= wr_data_in[`RTC_BIT_EN];
            end
            if (wr_en_in && wr_hit(addr_in, `RTC_OFS_MAIN))
            begin
                ctrl_q.h24 <= wr_data_in[`RTC_BIT_H24];
                ctrl_q.adj <= wr_data_in[`RTC_BIT_ADJ];
                ctrl_q.stp <= wr_data_in[`RTC_BIT_STP];
                ctrl_q.rst <= wr_data_in[`RTC_BIT_RST];
            end
            if (wr_en_in && wr_hit(addr_in, `RTC_OFS_ACC))
            begin
                read_buffer_enable_q <= wr_data_in[`RTC_BIT_RDBUF];
                counter_hold_q <= wr_data_in[`RTC_BIT_HOLD];
            end
        end
    end

    // Sticky interrupt status; a new event wins over a clear in the same cycle.
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            periodic_irq_pending_q <= 1'b0;
        end
        else if (per_evt)
        begin
            periodic_irq_pending_q <= 1'b1;
        end
        else if (soft_apply || (rd_en_in && wr_hit(addr_in, `RTC_OFS_STAT))
                 || (wr_en_in && wr_hit(addr_in, `RTC_OFS_STAT)
                     && wr_data_in[`RTC_BIT_PEND]))
        begin
            periodic_irq_pending_q <= 1'b0;
        end
    end

    // Edge-mode request: one cycle for each enabled event.
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            edge_q <= 1'b0;
        end
        else
        begin
            edge_q <= per_evt && periodic_irq_enable_q;
        end
    end

    // Interrupt request towards the processor.
    always_comb
    begin
        if (irq_level_mode_q)
        begin
            irq_out = periodic_irq_pending_q && periodic_irq_enable_q;
        end
        else
        begin
            irq_out = edge_q && periodic_irq_enable_q;
        end
    end

    // Pending one-second step; it waits while the counters are held.
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            sec_pend_q <= 1'b0;
        end
        else if (one_hz)
        begin
            sec_pend_q <= 1'b1;
        end
        else if (step)
        begin
            sec_pend_q <= 1'b0;
        end
    end

    assign counter_busy_out = sec_pend_q && !counter_hold_q;

    // Time and calendar counters; untouched by the software reset.
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            time_q <= '0;
            time_q.day <= 6'h01;
            time_q.mon <= 5'h01;
            time_q.hour <= 7'h12;
        end
        else if (wr_en_in && addr_in >= `RTC_OFS_SEC && addr_in <= `RTC_OFS_WEEK)
        begin
            unique case (addr_in)
                `RTC_OFS_SEC: time_q.sec <= wr_data_in[6:0];
                `RTC_OFS_MIN: time_q.min <= wr_data_in[6:0];
                `RTC_OFS_HOUR: time_q.hour <= wr_data_in[6:0];
                `RTC_OFS_DAY: time_q.day <= wr_data_in[5:0];
                `RTC_OFS_MON: time_q.mon <= wr_data_in[4:0];
                `RTC_OFS_YEAR: time_q.year <= wr_data_in;
                default: time_q.wk <= wr_data_in[2:0];
            endcase
        end
        else if (ctrl_q.adj)
        begin
            time_q.sec <= 7'h00;
            if (time_q.sec >= 7'h30)
            begin
                time_q <= carry_min(time_q, ctrl_q.h24);
            end
        end
        else if (step)
        begin
            if (time_q.sec == 7'h59)
            begin
                time_q <= carry_min(time_q, ctrl_q.h24);
            end
            else
            begin
                time_q.sec <= 7'(bcd_inc({1'b0, time_q.sec}));
            end
        end
    end

    // Read buffer: a seconds read latches a coherent copy of all counters.
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rdbuf_q <= '0;
        end
        else if (rd_en_in && wr_hit(addr_in, `RTC_OFS_SEC))
        begin
            rdbuf_q <= time_q;
        end
    end

    // Read data, valid in the cycle after the read strobe only.
    always_ff @(posedge mclk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rd_data_out <= 8'h00;
        end
        else if (!rd_en_in)
        begin
            rd_data_out <= 8'h00;
        end
        else
        begin
            rd_data_out <= 8'h00;
            unique case (addr_in)
                `RTC_OFS_GATE: rd_data_out <= {7'h00, clock_gate_on_q};
                `RTC_OFS_STAT: rd_data_out <= {7'h00, periodic_irq_pending_q};
                `RTC_OFS_SETUP: rd_data_out <= {3'h0, irq_period_select_q, irq_level_mode_q,
                                                periodic_irq_enable_q};
                `RTC_OFS_MAIN: rd_data_out <= {3'h0, ctrl_q.h24, 1'b0, ctrl_q.adj, ctrl_q.stp,
                                               ctrl_q.rst};
                `RTC_OFS_ACC: rd_data_out <= {5'h00, read_buffer_enable_q, counter_busy_out,
                                              counter_hold_q};
                `RTC_OFS_SEC: rd_data_out <= {1'b0, time_q.sec};
                `RTC_OFS_MIN: rd_data_out <= {1'b0, rd_view.min};
                `RTC_OFS_HOUR: rd_data_out <= {1'b0, rd_view.hour};
                `RTC_OFS_DAY: rd_data_out <= {2'h0, rd_view.day};
                `RTC_OFS_MON: rd_data_out <= {3'h0, rd_view.mon};
                `RTC_OFS_YEAR: rd_data_out <= rd_view.year;
                `RTC_OFS_WEEK: rd_data_out <= {5'h00, rd_view.wk};
                default: rd_data_out <= 8'h00;
            endcase
        end
    end

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!reset_n_in);

    // No oscillator tick while the gate is off.
    property p_gate_off;
        !clock_gate_on_q ##1 !clock_gate_on_q |-> !osc_tick_q;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("tick while gated");

    // An event shows in the status bit next cycle.
    property p_irq_set;
        per_evt |=> periodic_irq_pending_q;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("status not set");

    // Writing 1 clears the status when no event coincides.
    property p_irq_clear;
        wr_en_in && addr_in == `RTC_OFS_STAT && wr_data_in[0] && !per_evt
            |=> !periodic_irq_pending_q;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("status not cleared");

    // Code 5 fires whenever the low seven divider bits roll over, every 128 ticks.
    property p_period;
        div_run && irq_period_select_q == 3'h5 && div_q[6:0] == 7'h7f |-> per_evt;
    endproperty
    a_period: assert property (p_period) else $error("bad event spacing");

    // Masked requests never reach the processor.
    property p_mask;
        !periodic_irq_enable_q |-> !irq_out;
    endproperty
    a_mask: assert property (p_mask) else $error("masked irq seen");

    // Level mode keeps the request while status stays set.
    property p_level;
        irq_level_mode_q && periodic_irq_enable_q && periodic_irq_pending_q |-> irq_out;
    endproperty
    a_level: assert property (p_level) else $error("level irq missing");

    // The divider does not move while stopped.
    property p_stop;
        ctrl_q.stp |=> $stable(div_q);
    endproperty
    a_stop: assert property (p_stop) else $error("divider ran while stopped");

    // Software reset restores the setup defaults and keeps the counters.
    property p_soft;
        soft_apply && !step |=> irq_period_select_q == 3'h1 && irq_level_mode_q
            && !periodic_irq_enable_q && time_q == $past(time_q);
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset wrong");

    // Held counters stay still without writes.
    property p_hold;
        counter_hold_q && !wr_en_in && !ctrl_q.adj |=> $stable(time_q);
    endproperty
    a_hold: assert property (p_hold) else $error("counters moved in hold");

    // A second boundary raises busy unless held.
    property p_busy;
        one_hz && !counter_hold_q ##1 !counter_hold_q |-> counter_busy_out;
    endproperty
    a_busy: assert property (p_busy) else $error("busy missing");

endmodule

// >>> pkg/rtc_defines.svh
// Register offsets, field positions, reset values and timing constants of the calendar clock.
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH
`define RTC_OFS_GATE 16'h506e
`define RTC_OFS_STAT 16'h5140
`define RTC_OFS_SETUP 16'h5141
`define RTC_OFS_MAIN 16'h5142
`define RTC_OFS_ACC 16'h5143
`define RTC_OFS_SEC 16'h5144
`define RTC_OFS_MIN 16'h5145
`define RTC_OFS_HOUR 16'h5146
`define RTC_OFS_DAY 16'h5147
`define RTC_OFS_MON 16'h5148
`define RTC_OFS_YEAR 16'h5149
`define RTC_OFS_WEEK 16'h514a
`define RTC_BIT_GATE 0
`define RTC_BIT_PEND 0
`define RTC_BIT_EN 0
`define RTC_BIT_LEVEL 1
`define RTC_PER_LSB 2
`define RTC_PER_MSB 4
`define RTC_BIT_RST 0
`define RTC_BIT_STP 1
`define RTC_BIT_ADJ 2
`define RTC_BIT_H24 4
`define RTC_BIT_HOLD 0
`define RTC_BIT_BUSY 1
`define RTC_BIT_RDBUF 2
`define RTC_PER_RST 3'h1
`define RTC_PER_RSVD 3'h7
`define RTC_LEVEL_RST 1'b1
`define RTC_MCLK_HZ 100000000
`define RTC_OSC_HZ 32768
`endif

// >>> pkg/rtc_pkg.sv
// Types shared by the calendar clock design.
package rtc_pkg;
    // One snapshot of all time and calendar counters, BCD coded.
    typedef struct packed {
        logic [6:0] sec;
        logic [6:0] min;
        logic [6:0] hour;
        logic [5:0] day;
        logic [4:0] mon;
        logic [7:0] year;
        logic [2:0] wk;
    } time_s;
    // Control bits of the main control register.
    typedef struct packed {
        logic h24;
        logic adj;
        logic stp;
        logic rst;
    } ctrl_s;
endpackage

// >>> test/bcd_calendar_rtc_tb.sv
// Self-checking testbench for the BCD calendar real-time clock.
`timescale 1ns/1ns
`include "rtc_defines.svh"

module bcd_calendar_rtc_tb;
    // Design connections.
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [15:0] addr_in = 16'h0000;
    logic [7:0] wr_data_in = 8'h00;
    logic wr_en_in = 1'b0;
    logic rd_en_in = 1'b0;
    logic [7:0] rd_data_out;
    logic irq_out;
    logic counter_busy_out;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;

    // Divider shortened so one oscillator tick is two system cycles.
    bcd_calendar_rtc #(.OSC_DIV(2)) DUT (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .addr_in(addr_in),
        .wr_data_in(wr_data_in),
        .wr_en_in(wr_en_in),
        .rd_en_in(rd_en_in),
        .rd_data_out(rd_data_out),
        .irq_out(irq_out),
        .counter_busy_out(counter_busy_out)
    );

    // System clock at 100 MHz.
    initial
    begin
        forever #5 mclk_in = ~mclk_in;
    end

    // Cycle count; the ceiling cuts a hang short.
    always @(posedge mclk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            n_errors++;
            conclude();
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic conclude();
        $display("errors %0d, checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Compares a seen value with the expected one.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // One-cycle register write.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        wr_en_in <= 1'b1;
        addr_in <= a;
        wr_data_in <= d;
        @(posedge mclk_in);
        wr_en_in <= 1'b0;
    endtask

    // One-cycle register read; data is taken in the following cycle.
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        rd_en_in <= 1'b1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_en_in <= 1'b0;
        #1;
        d = rd_data_out;
    endtask

    // Reads a register and compares it.
    task automatic chk_rd(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check(d, exp);
    endtask

    // Waits a bounded time for the interrupt; returns its cycle or -1.
    task automatic wait_irq(input int max, output int at);
        at = -1;
        for (int i = 0; i < max; i++)
        begin
            @(posedge mclk_in);
            #1;
            if (irq_out === 1'b1)
            begin
                at = cyc;
                break;
            end
        end
    endtask

    // Reset values, reserved bits, read-only busy bit and unmapped reads.
    task automatic t_regs();
        logic [15:0] a[9] = '{`RTC_OFS_SEC, `RTC_OFS_MIN, `RTC_OFS_HOUR, `RTC_OFS_DAY,
            `RTC_OFS_MON, `RTC_OFS_YEAR, `RTC_OFS_WEEK, `RTC_OFS_SETUP, `RTC_OFS_GATE};
        logic [7:0] w[9] = '{8'hd9, 8'ha7, 8'h92, 8'hf1, 8'hf2, 8'h99, 8'hfe, 8'hff, 8'hfe};
        logic [7:0] e[9] = '{8'h59, 8'h27, 8'h12, 8'h31, 8'h12, 8'h99, 8'h06, 8'h1f, 8'h00};
        check(irq_out, 1'b0);
        chk_rd(`RTC_OFS_GATE, 8'h00);
        chk_rd(`RTC_OFS_SETUP, 8'h06);
        chk_rd(`RTC_OFS_MAIN, 8'h00);
        chk_rd(`RTC_OFS_ACC, 8'h00);
        chk_rd(`RTC_OFS_STAT, 8'h00);
        chk_rd(`RTC_OFS_HOUR, 8'h12);
        chk_rd(16'h5150, 8'h00);
        for (int i = 0; i < 9; i++)
        begin
            wr(a[i], w[i]);
            chk_rd(a[i], e[i]);
        end
        wr(`RTC_OFS_ACC, 8'hff);
        chk_rd(`RTC_OFS_ACC, 8'h05);
    endtask

    // Software reset restores control bits and keeps the counters.
    task automatic t_soft_reset();
        wr(`RTC_OFS_SETUP, 8'h11);
        wr(`RTC_OFS_MAIN, 8'h10);
        wr(`RTC_OFS_MAIN, 8'h01);
        wr(`RTC_OFS_MAIN, 8'h00);
        chk_rd(`RTC_OFS_SETUP, 8'h06);
        chk_rd(`RTC_OFS_MAIN, 8'h00);
        chk_rd(`RTC_OFS_ACC, 8'h00);
        chk_rd(`RTC_OFS_SEC, 8'h59);
        chk_rd(`RTC_OFS_YEAR, 8'h99);
    endtask

    // A seconds read latches the copy that other counter reads then return.
    task automatic t_read_buffer();
        logic [7:0] d;
        wr(`RTC_OFS_ACC, 8'h04);
        rd(`RTC_OFS_SEC, d);
        wr(`RTC_OFS_MIN, 8'h33);
        chk_rd(`RTC_OFS_MIN, 8'h27);
        wr(`RTC_OFS_ACC, 8'h00);
        chk_rd(`RTC_OFS_MIN, 8'h33);
    endtask

    // Loads a time, adjusts by half a minute and compares every counter.
    task automatic adj(input logic h24, input logic [55:0] v, input logic [55:0] e);
        for (int i = 0; i < 7; i++)
            wr(`RTC_OFS_SEC + 16'(i), v[8*i+:8]);
        wr(`RTC_OFS_MAIN, {3'b000, h24, 4'b0100});
        repeat (2) @(posedge mclk_in);
        for (int i = 0; i < 7; i++)
            chk_rd(`RTC_OFS_SEC + 16'(i), e[8*i+:8]);
    endtask

    // Carries through every counter in 24-hour format and through the day and weekday in 12-hour format.
    task automatic t_adjust();
        adj(1'b1, 56'h06_23_02_28_23_59_45, 56'h00_23_03_01_00_00_00);
        adj(1'b0, 56'h02_24_02_28_51_59_31, 56'h03_24_02_29_12_00_00);
        adj(1'b1, 56'h01_99_12_31_23_59_30, 56'h02_00_01_01_00_00_00);
        adj(1'b0, 56'h04_10_10_15_12_59_40, 56'h04_10_10_15_01_00_00);
        adj(1'b1, 56'h05_10_10_15_09_10_15, 56'h05_10_10_15_09_10_00);
    endtask

    // Runs a setup where no interrupt may reach the output.
    task automatic quiet(input logic [7:0] setup, gate, main, input logic [7:0] stat);
        logic hit;
        logic [7:0] d;
        hit = 1'b0;
        wr(`RTC_OFS_GATE, gate);
        wr(`RTC_OFS_MAIN, main);
        wr(`RTC_OFS_SETUP, setup);
        rd(`RTC_OFS_STAT, d);
        repeat (300)
        begin
            @(posedge mclk_in);
            #1;
            if (irq_out !== 1'b0)
                hit = 1'b1;
        end
        check(hit, 1'b0);
        chk_rd(`RTC_OFS_STAT, stat);
    endtask

    // Masking, reserved cycle code, clock gate and divider stop.
    task automatic t_quiet();
        quiet(8'h12, 8'h01, 8'h00, 8'h01);
        quiet(8'h1f, 8'h01, 8'h00, 8'h00);
        quiet(8'h13, 8'h00, 8'h00, 8'h00);
        quiet(8'h13, 8'h01, 8'h02, 8'h00);
    endtask

    // Interrupt periods, level and edge signalling, clearing by read and write.
    task automatic t_irq();
        int t0;
        int t1;
        logic [7:0] d;
        wr(`RTC_OFS_MAIN, 8'h00);
        for (int c = 4; c < 7; c++)
        begin
            wr(`RTC_OFS_SETUP, {3'b000, 3'(c), 2'b11});
            rd(`RTC_OFS_STAT, d);
            wait_irq(1200, t0);
            check(t0 > 0, 1'b1);
            rd(`RTC_OFS_STAT, d);
            check(d, 8'h01);
            check(irq_out, 1'b0);
            wait_irq(1200, t1);
            // Code c spans 2^(c+2) ticks of two system cycles each.
            check(t1 - t0, 32'd1 << (c + 3));
            repeat (3) @(posedge mclk_in);
            #1;
            check(irq_out, 1'b1);
            wr(`RTC_OFS_STAT, 8'h01);
            #1;
            check(irq_out, 1'b0);
        end
        wr(`RTC_OFS_SETUP, 8'h11);
        wait_irq(300, t0);
        check(t0 > 0, 1'b1);
        @(posedge mclk_in);
        #1;
        check(irq_out, 1'b0);
    endtask

    // Hold defers the one-second step; release lets it through with busy.
    task automatic t_hold();
        int b;
        wr(`RTC_OFS_SETUP, 8'h12);
        wr(`RTC_OFS_SEC, 8'h20);
        wr(`RTC_OFS_ACC, 8'h01);
        wr(`RTC_OFS_GATE, 8'h01);
        repeat (66000) @(posedge mclk_in);
        chk_rd(`RTC_OFS_SEC, 8'h20);
        wr(`RTC_OFS_ACC, 8'h00);
        b = 0;
        for (int i = 0; i < 10 && b == 0; i++)
        begin
            #1;
            if (counter_busy_out === 1'b1)
                b = 1;
            @(posedge mclk_in);
        end
        check(b, 1);
        repeat (3) @(posedge mclk_in);
        chk_rd(`RTC_OFS_SEC, 8'h21);
    endtask

    // Main sequence.
    initial
    begin
        repeat (12) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        t_regs();
        t_soft_reset();
        t_read_buffer();
        t_adjust();
        t_quiet();
        t_irq();
        t_hold();
        conclude();
    end
endmodule
